// [hw/pmic_flag_pkg.sv]
/*
 * Constants for the main-domain status flag bank: register indices,
 * field positions, reset values and the monitor source code table.
 * Assumes the register data word is the 16-bit payload of one serial
 * register access, with payload bit 0 standing for register bit 8.
 */
// Summary of operation
// - Regulator event flags set sticky, write one clears
// - Invalid main access sets sticky error flag
// - Checksum failure sets sticky error flag
// - First wake input level read live
// - Second wake input level read live
// - Clock watchdog bit high when clock in range
// - Each regulator has live on/off bit
// - First monitor source decoded by eight-code table
// - Other monitors same table, reset to external
// - Monitor fields contiguous at bits 8 to 19
package pmic_flag_pkg;

    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned SEL_W  = 3;
    localparam int unsigned MON_N  = 4;
    localparam int unsigned SRC_N  = 8;

    // Register indices on the access port
    localparam logic [ADDR_W-1:0] IDX_FLAGS_TWO   = 2'h0;
    localparam logic [ADDR_W-1:0] IDX_FLAGS_THREE = 2'h1;
    localparam logic [ADDR_W-1:0] IDX_MON_ASSIGN  = 2'h2;

    // Event flags two, payload positions of register bits 20..23
    localparam int unsigned POS_STEP_UP_UV   = 12;
    localparam int unsigned POS_BIAS_UV      = 13;
    localparam int unsigned POS_SELFTEST     = 14;
    localparam int unsigned POS_CENTRAL_TEMP = 15;
    localparam int unsigned EVT_LSB          = 12;
    localparam int unsigned EVT_N            = 4;

    // Event flags three
    localparam int unsigned POS_ACCESS_ERR  = 0;
    localparam int unsigned POS_CRC_ERR     = 1;
    localparam int unsigned POS_WAKE_ONE    = 2;
    localparam int unsigned POS_WAKE_TWO    = 3;
    localparam int unsigned POS_CLK_OK      = 6;
    localparam int unsigned POS_REG_STATE   = 7;
    localparam int unsigned REG_N           = 9;

    // Monitor assignment register
    localparam int unsigned POS_MON_SEL     = 0;

    localparam logic [DATA_W-1:0] RST_FLAGS   = 16'h0000;
    localparam logic [DATA_W-1:0] RST_MON     = 16'h0000;
    localparam logic [SEL_W-1:0]  RST_SEL     = 3'h0;
    localparam logic [SRC_N-1:0]  RST_ONEHOT  = 8'h01;

    // Monitor source codes
    localparam logic [SEL_W-1:0] SRC_EXTERNAL     = 3'h0;
    localparam logic [SEL_W-1:0] SRC_PRE_REG      = 3'h1;
    localparam logic [SEL_W-1:0] SRC_LINEAR_ONE   = 3'h2;
    localparam logic [SEL_W-1:0] SRC_LINEAR_TWO   = 3'h3;
    localparam logic [SEL_W-1:0] SRC_STEP_DOWN3   = 3'h4;
    localparam logic [SEL_W-1:0] SRC_STEP_UP      = 3'h5;
    localparam logic [SEL_W-1:0] SRC_LINEAR_THREE = 3'h6;
    localparam logic [SEL_W-1:0] SRC_STEP_DOWN2   = 3'h7;

    // One-hot source bit positions
    localparam int unsigned SH_EXTERNAL     = 0;
    localparam int unsigned SH_PRE_REG      = 1;
    localparam int unsigned SH_LINEAR_ONE   = 2;
    localparam int unsigned SH_LINEAR_TWO   = 3;
    localparam int unsigned SH_STEP_DOWN3   = 4;
    localparam int unsigned SH_STEP_UP      = 5;
    localparam int unsigned SH_LINEAR_THREE = 6;
    localparam int unsigned SH_STEP_DOWN2   = 7;

endpackage

// [hw/monitor_source_decode.sv]
/*
 * Registered decoder from one monitor channel's 3-bit source code to a
 * one-hot regulator select.
 * Assumes the code comes from logic on the same clock.
 */
module monitor_source_decode (
    input  wire logic                              sys_clk,    // 25 MHz clock
    input  wire logic                              rst_n,      // Async reset
    input  wire logic                              clk_en,     // Freeze when low
    input  wire logic [pmic_flag_pkg::SEL_W-1:0]   source_sel, // Source code
    output logic      [pmic_flag_pkg::SRC_N-1:0]   source_hot  // One-hot select
);

    logic [pmic_flag_pkg::SRC_N-1:0] nxt_hot;

    always_comb begin
        nxt_hot = '0;
        case (source_sel)
            pmic_flag_pkg::SRC_EXTERNAL:     nxt_hot[pmic_flag_pkg::SH_EXTERNAL]     = 1'b1;
            pmic_flag_pkg::SRC_PRE_REG:      nxt_hot[pmic_flag_pkg::SH_PRE_REG]      = 1'b1;
            pmic_flag_pkg::SRC_LINEAR_ONE:   nxt_hot[pmic_flag_pkg::SH_LINEAR_ONE]   = 1'b1;
            pmic_flag_pkg::SRC_LINEAR_TWO:   nxt_hot[pmic_flag_pkg::SH_LINEAR_TWO]   = 1'b1;
            pmic_flag_pkg::SRC_STEP_DOWN3:   nxt_hot[pmic_flag_pkg::SH_STEP_DOWN3]   = 1'b1;
            pmic_flag_pkg::SRC_STEP_UP:      nxt_hot[pmic_flag_pkg::SH_STEP_UP]      = 1'b1;
            pmic_flag_pkg::SRC_LINEAR_THREE: nxt_hot[pmic_flag_pkg::SH_LINEAR_THREE] = 1'b1;
            pmic_flag_pkg::SRC_STEP_DOWN2:   nxt_hot[pmic_flag_pkg::SH_STEP_DOWN2]   = 1'b1;
            default:                         nxt_hot[pmic_flag_pkg::SH_EXTERNAL]     = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            source_hot <= pmic_flag_pkg::RST_ONEHOT;
        end else if (clk_en) begin
            source_hot <= nxt_hot;
        end
    end

endmodule

// [hw/pmic_status_flag_bank.sv]
/*
 * Main-domain status flag bank: sticky event flags of register two's top
 * nibble, event flags three with live wake and regulator states, and the
 * voltage monitor source assignment register.
 * Assumes the serial front end on the same clock delivers decoded
 * register accesses as one-cycle strobes and reports frame errors as
 * one-cycle pulses; analog status levels arrive asynchronously.
 */
module pmic_status_flag_bank (
    input  wire logic                                   sys_clk,          // 25 MHz clock
    input  wire logic                                   rst_n,            // Power-on reset
    input  wire logic                                   clk_en,           // Freeze when low
    // Register access port from serial front end
    input  wire logic                                   reg_wr,           // Write strobe
    input  wire logic                                   reg_rd,           // Read strobe
    input  wire logic [pmic_flag_pkg::ADDR_W-1:0]       reg_idx,          // Register index
    input  wire logic [pmic_flag_pkg::DATA_W-1:0]       reg_wdata,        // Write payload
    output logic      [pmic_flag_pkg::DATA_W-1:0]       reg_rdata,        // Read payload
    output logic                                        reg_rvalid,       // Read data valid
    // Serial front end error pulses, same clock
    input  wire logic                                   access_err_pulse, // Invalid access
    input  wire logic                                   crc_err_pulse,    // Frame CRC failed
    // Asynchronous status levels
    input  wire logic                                   step_up_uv,       // Step-up undervoltage
    input  wire logic                                   bias_uv,          // Bias undervoltage
    input  wire logic                                   selftest_fail,    // Thermal self-test bad
    input  wire logic                                   central_hot,      // Central die thermal
    input  wire logic                                   wake_input_one,   // Wake pin one
    input  wire logic                                   wake_input_two,   // Wake pin two
    input  wire logic                                   ext_clock_ok,     // Clock monitor good
    input  wire logic [pmic_flag_pkg::REG_N-1:0]        regulator_on,     // Regulators on, LSB linear_three
    // Monitor source selects, one-hot per channel
    output logic      [pmic_flag_pkg::SRC_N*pmic_flag_pkg::MON_N-1:0] monitor_source_hot // Selects
);

    localparam int unsigned ASYNC_N = pmic_flag_pkg::EVT_N + 3 + pmic_flag_pkg::REG_N;

    logic [ASYNC_N-1:0]                  meta_ff;
    logic [ASYNC_N-1:0]                  sync_ff;
    logic [pmic_flag_pkg::EVT_N-1:0]     evt_flag_ff;
    logic [pmic_flag_pkg::EVT_N-1:0]     nxt_evt_flag;
    logic                                access_err_ff;
    logic                                crc_err_ff;
    logic [pmic_flag_pkg::SEL_W*pmic_flag_pkg::MON_N-1:0] mon_sel_ff;
    logic [pmic_flag_pkg::DATA_W-1:0]    nxt_rdata;

    wire logic [ASYNC_N-1:0] async_in = {regulator_on, ext_clock_ok, wake_input_two,
                                         wake_input_one, central_hot, selftest_fail,
                                         bias_uv, step_up_uv};

    wire logic [pmic_flag_pkg::EVT_N-1:0] evt_now  = sync_ff[pmic_flag_pkg::EVT_N-1:0];
    wire logic                            wake_one = sync_ff[pmic_flag_pkg::EVT_N];
    wire logic                            wake_two = sync_ff[pmic_flag_pkg::EVT_N+1];
    wire logic                            clk_ok   = sync_ff[pmic_flag_pkg::EVT_N+2];
    wire logic [pmic_flag_pkg::REG_N-1:0] reg_live = sync_ff[ASYNC_N-1:pmic_flag_pkg::EVT_N+3];

    wire logic wr_two   = reg_wr && (reg_idx == pmic_flag_pkg::IDX_FLAGS_TWO);
    wire logic wr_three = reg_wr && (reg_idx == pmic_flag_pkg::IDX_FLAGS_THREE);
    wire logic wr_mon   = reg_wr && (reg_idx == pmic_flag_pkg::IDX_MON_ASSIGN);

    // Only one bits clear; zeros leave the flag alone
    wire logic [pmic_flag_pkg::EVT_N-1:0] evt_clr = wr_two ?
        reg_wdata[pmic_flag_pkg::EVT_LSB +: pmic_flag_pkg::EVT_N] : '0;
    wire logic acc_clr = wr_three && reg_wdata[pmic_flag_pkg::POS_ACCESS_ERR];
    wire logic crc_clr = wr_three && reg_wdata[pmic_flag_pkg::POS_CRC_ERR];

    // Set wins over a simultaneous clear so a persisting event is kept
    assign nxt_evt_flag = (evt_flag_ff & ~evt_clr) | evt_now;

    wire logic [pmic_flag_pkg::DATA_W-1:0] flags_two_word =
        {evt_flag_ff, {pmic_flag_pkg::EVT_LSB{1'b0}}};

    wire logic [pmic_flag_pkg::DATA_W-1:0] flags_three_word =
        {reg_live, clk_ok, 2'b00, wake_two, wake_one, crc_err_ff, access_err_ff};

    // Fields packed from bit 0 upward; unused upper bits read zero
    wire logic [pmic_flag_pkg::DATA_W-1:0] mon_word =
        {{(pmic_flag_pkg::DATA_W-pmic_flag_pkg::SEL_W*pmic_flag_pkg::MON_N){1'b0}},
         mon_sel_ff};

    always_comb begin
        case (reg_idx)
            pmic_flag_pkg::IDX_FLAGS_TWO:   nxt_rdata = flags_two_word;
            pmic_flag_pkg::IDX_FLAGS_THREE: nxt_rdata = flags_three_word;
            pmic_flag_pkg::IDX_MON_ASSIGN:  nxt_rdata = mon_word;
            default:                        nxt_rdata = '0;
        endcase
    end

    // Two-stage synchroniser for all analog and pin levels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else if (clk_en) begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_flag_ff <= pmic_flag_pkg::RST_FLAGS[pmic_flag_pkg::EVT_LSB +: pmic_flag_pkg::EVT_N];
        end else if (clk_en) begin
            evt_flag_ff <= nxt_evt_flag;
        end
    end

    // Error flags: a new error in the clearing cycle survives
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            access_err_ff <= 1'b0;
            crc_err_ff    <= 1'b0;
        end else if (clk_en) begin
            access_err_ff <= (access_err_ff && !acc_clr) || access_err_pulse;
            crc_err_ff    <= (crc_err_ff && !crc_clr) || crc_err_pulse;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mon_sel_ff <= pmic_flag_pkg::RST_MON[pmic_flag_pkg::SEL_W*pmic_flag_pkg::MON_N-1:0];
        end else if (clk_en && wr_mon) begin
            mon_sel_ff <= reg_wdata[pmic_flag_pkg::SEL_W*pmic_flag_pkg::MON_N-1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= pmic_flag_pkg::RST_FLAGS;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= nxt_rdata;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < pmic_flag_pkg::MON_N; ch++) begin : g_mon
            monitor_source_decode u_dec (
                .sys_clk    (sys_clk),
                .rst_n      (rst_n),
                .clk_en     (clk_en),
                .source_sel (mon_sel_ff[ch*pmic_flag_pkg::SEL_W +: pmic_flag_pkg::SEL_W]),
                .source_hot (monitor_source_hot[ch*pmic_flag_pkg::SRC_N +: pmic_flag_pkg::SRC_N])
            );
        end
    endgenerate

endmodule

// [dv/pmic_flag_sva.sv]
/* Port checker for the status flag bank: read timing, error flags,
   reserved bits, live wake bits and monitor decode.
   Assumes one clock domain and is bound to the top module. */
module pmic_flag_sva (
    input wire logic        sys_clk,            // Clock
    input wire logic        rst_n,              // Reset
    input wire logic        clk_en,             // Enable
    input wire logic        reg_wr,             // Write strobe
    input wire logic        reg_rd,             // Read strobe
    input wire logic [1:0]  reg_idx,            // Index
    input wire logic [15:0] reg_wdata,          // Write data
    input wire logic [15:0] reg_rdata,          // Read data
    input wire logic        reg_rvalid,         // Read valid
    input wire logic        access_err_pulse,   // Access error
    input wire logic        crc_err_pulse,      // CRC error
    input wire logic        wake_input_one,     // Wake one
    input wire logic        wake_input_two,     // Wake two
    input wire logic [31:0] monitor_source_hot  // Selects
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(logic [1:0] i);
        clk_en && reg_rd && reg_idx == i;
    endsequence
    // No write may clear the flag between the error and the read
    sequence s_gap;
        clk_en && !reg_wr ##1 s_rd(2'h1);
    endsequence
    property p_rvalid;
        clk_en && reg_rd |=> reg_rvalid;
    endproperty
    property p_no_rvalid;
        clk_en && !reg_rd |=> !reg_rvalid;
    endproperty
    property p_crc;
        crc_err_pulse && clk_en ##1 s_gap |=> reg_rdata[1];
    endproperty
    property p_access;
        access_err_pulse && clk_en ##1 s_gap |=> reg_rdata[0];
    endproperty
    property p_unmapped;
        s_rd(2'h3) |=> reg_rdata == 16'h0000;
    endproperty
    property p_rsv_two;
        s_rd(2'h0) |=> reg_rdata[11:0] == 12'h000;
    endproperty
    property p_rsv_mon;
        s_rd(2'h2) |=> reg_rdata[15:12] == 4'h0;
    endproperty
    property p_wake;
        (clk_en && wake_input_one && !wake_input_two)[*4] ##0 s_rd(2'h1)
            |=> reg_rdata[3:2] == 2'b01;
    endproperty
    property p_mon;
        clk_en && reg_wr && reg_idx == 2'h2 ##1 clk_en |=>
            monitor_source_hot[7:0] == 8'h01 << $past(reg_wdata[2:0], 2) &&
            monitor_source_hot[31:24] == 8'h01 << $past(reg_wdata[11:9], 2);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    a_no_rvalid: assert property (p_no_rvalid) else $error("stray read valid");
    a_crc: assert property (p_crc) else $error("crc flag not set");
    a_access: assert property (p_access) else $error("access flag not set");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    a_rsv_two: assert property (p_rsv_two) else $error("flags two low bits set");
    a_rsv_mon: assert property (p_rsv_mon) else $error("monitor reserved set");
    a_wake: assert property (p_wake) else $error("wake bits wrong");
    a_mon: assert property (p_mon) else $error("monitor select wrong");
endmodule

bind pmic_status_flag_bank pmic_flag_sva u_sva (.sys_clk, .rst_n, .clk_en, .reg_wr,
    .reg_rd, .reg_idx, .reg_wdata, .reg_rdata, .reg_rvalid, .access_err_pulse,
    .crc_err_pulse, .wake_input_one, .wake_input_two, .monitor_source_hot);

// [dv/host_model.sv]
/* Host microcontroller model issuing decoded register strobes.
   Assumes the bank answers a read one cycle after its strobe. */
module host_model (
    input  wire logic        sys_clk,   // Clock
    output logic             reg_wr,    // Write strobe
    output logic             reg_rd,    // Read strobe
    output logic [1:0]       reg_idx,   // Index
    output logic [15:0]      reg_wdata, // Write data
    input  wire logic [15:0] reg_rdata, // Read data
    input  wire logic        reg_rvalid // Read valid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_idx = 2'h0;
        reg_wdata = 16'h0000;
    end
    task automatic wr(input logic [1:0] i, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_idx <= i;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [1:0] i, output logic [15:0] d, output logic ok);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_idx <= i;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        // Answer stands for the cycle after the strobe; sample it settled
        @(negedge sys_clk);
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
    // Start-up sweep of every flag bit
    task automatic clear_all;
        wr(2'h0, 16'hFFFF);
        wr(2'h1, 16'hFFFF);
    endtask
endmodule

// [dv/tb_top.sv]
/* Self-checking bench for the status flag bank.
   Assumes the host model drives the register strobes. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst_n = 0, clk_en = 1, reg_wr, reg_rd, reg_rvalid;
    logic access_err_pulse = 0, crc_err_pulse = 0, step_up_uv = 0, bias_uv = 0;
    logic selftest_fail = 0, central_hot = 0, wake_input_one = 0;
    logic wake_input_two = 0, ext_clock_ok = 0;
    logic [1:0] reg_idx;
    logic [15:0] reg_wdata, reg_rdata;
    logic [8:0] regulator_on = 9'h000;
    logic [31:0] monitor_source_hot;
    int failures = 0, comparisons = 0;
    always #20 sys_clk = ~sys_clk;
    pmic_status_flag_bank dut (.sys_clk, .rst_n, .clk_en, .reg_wr, .reg_rd,
        .reg_idx, .reg_wdata, .reg_rdata, .reg_rvalid, .access_err_pulse,
        .crc_err_pulse, .step_up_uv, .bias_uv, .selftest_fail, .central_hot,
        .wake_input_one, .wake_input_two, .ext_clock_ok, .regulator_on,
        .monitor_source_hot);
    host_model host (.sys_clk, .reg_wr, .reg_rd, .reg_idx, .reg_wdata,
        .reg_rdata, .reg_rvalid);
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input logic [1:0] i, input logic [15:0] e, input string n);
        logic [15:0] d;
        logic ok;
        host.rd(i, d, ok);
        chk("read valid", 32'h1, {31'h0, ok});
        chk(n, {16'h0, e}, {16'h0, d});
    endtask
    task automatic ev(input logic [3:0] e);
        @(posedge sys_clk);
        {central_hot, selftest_fail, bias_uv, step_up_uv} <= e;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic t_events;
        ev(4'hF);
        host.wr(2'h0, 16'hF000);
        rdchk(2'h0, 16'hF000, "flags held");
        ev(4'h0);
        host.wr(2'h0, 16'h0000);
        rdchk(2'h0, 16'hF000, "zero write");
        host.wr(2'h0, 16'h5FFF);
        rdchk(2'h0, 16'hA000, "partial clear");
        $display("test events done");
    endtask
    task automatic t_errs;
        @(posedge sys_clk);
        {crc_err_pulse, access_err_pulse} <= 2'b11;
        @(posedge sys_clk);
        {crc_err_pulse, access_err_pulse} <= 2'b00;
        rdchk(2'h1, 16'h0003, "error flags");
        host.wr(2'h1, 16'h0002);
        rdchk(2'h1, 16'h0001, "crc cleared");
        host.wr(2'h1, 16'h0001);
        rdchk(2'h1, 16'h0000, "access cleared");
        $display("test errors done");
    endtask
    task automatic t_live;
        logic b;
        logic [8:0] r;
        for (int i = 0; i < 2; i++) begin
            b = (i == 0);
            r = b ? 9'h155 : 9'h0AA;
            @(posedge sys_clk);
            {wake_input_one, wake_input_two, ext_clock_ok, regulator_on} <= {b, !b, b, r};
            repeat (4) @(posedge sys_clk);
            host.wr(2'h1, 16'hFFFC);
            rdchk(2'h1, {r, b, 2'b00, !b, b, 2'b00}, "live state");
        end
        $display("test live done");
    endtask
    task automatic t_mon;
        logic [2:0] s;
        logic [15:0] d;
        for (int c = 0; c < 8; c++) begin
            s = 3'(c);
            d = {4'hF, s + 3'd3, s + 3'd2, s + 3'd1, s};
            host.wr(2'h2, d);
            rdchk(2'h2, {4'h0, d[11:0]}, "monitor fields");
            chk("monitor hot", {8'h01 << (s + 3'd3), 8'h01 << (s + 3'd2),
                8'h01 << (s + 3'd1), 8'h01 << s}, monitor_source_hot);
        end
        host.wr(2'h3, 16'hFFFF);
        rdchk(2'h3, 16'h0000, "unmapped");
        $display("test monitor done");
    endtask
    // A write while the enable is low must leave every field untouched
    task automatic t_freeze;
        host.wr(2'h2, 16'h0000);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        host.wr(2'h2, 16'h0FFF);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rdchk(2'h2, 16'h0000, "frozen write");
        chk("frozen hot", 32'h0101_0101, monitor_source_hot);
        $display("test freeze done");
    endtask
    task automatic results;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        results();
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        chk("monitor hot", 32'h0101_0101, monitor_source_hot);
        rdchk(2'h1, 16'h0000, "flags three");
        rdchk(2'h2, 16'h0000, "monitor reset");
        host.clear_all();
        t_events();
        t_errs();
        t_live();
        t_mon();
        t_freeze();
        results();
    end
endmodule
